// [common/ctsr_cfg.svh]
`ifndef CTSR_CFG_SVH
`define CTSR_CFG_SVH

// Host I/O port addresses
`define CTSR_PORT_DTCU_IDX_MONO 16'h03b4
`define CTSR_PORT_DTCU_DAT_MONO 16'h03b5
`define CTSR_PORT_DTCU_IDX_COLR 16'h03d4
`define CTSR_PORT_DTCU_DAT_COLR 16'h03d5
`define CTSR_PORT_EXT_IDX 16'h03c4
`define CTSR_PORT_EXT_DAT 16'h03c5

// Register indices
`define CTSR_IDX_TEST 8'h2f
`define CTSR_IDX_LOCK 8'h81
`define CTSR_IDX_SCRATCH_BASE 8'h88
`define CTSR_IDX_SCRATCH_MODE 8'h8e

// Test register fields and reset values
`define CTSR_TEST_VCNT5 7
`define CTSR_TEST_VCNT4 6
`define CTSR_TEST_HCNT5A 5
`define CTSR_TEST_HCNT5B 4
`define CTSR_TEST_FORCE_POL 0
`define CTSR_TEST_WR_MASK 8'hf1
`define CTSR_TEST_RESET 8'h00
`define CTSR_SCRATCH_RESET 8'h00
`define CTSR_BYTE_ZERO 8'h00
`define CTSR_SCRATCH_COUNT 8

`endif

// [common/ctsr_pkg.sv]
package ctsr_pkg;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } ctsr_io_req_t;

   typedef struct packed {
      logic vcnt_upper5;
      logic vcnt_upper4;
      logic hcnt_upper5;
   } ctsr_step_t;

   typedef struct packed {
      logic hsync_high;
      logic vsync_high;
   } ctsr_pol_t;

   typedef struct packed {
      logic [7:0] dtcu_idx;
      logic [7:0] ext_idx;
      logic [7:0] test;
      logic [7:0] rdata;
      ctsr_step_t step;
      ctsr_pol_t pol;
   } ctsr_state_t;

endpackage

// [rtl/ctsr_scratch.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ctsr_cfg.svh"

module ctsr_scratch #(
   parameter int DEPTH = `CTSR_SCRATCH_COUNT
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] sel,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);

   typedef struct packed {
      logic [DEPTH-1:0][7:0] mem;
   } ctsr_scr_state_t;

   ctsr_scr_state_t s_q;
   ctsr_scr_state_t s_d;

   // Plain storage: contents steer no hardware
   always_comb begin
      s_d = s_q;
      if (wr_en) begin
         s_d.mem[sel] = wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_q <= '{mem: {DEPTH{`CTSR_SCRATCH_RESET}}};
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.mem[sel];

endmodule

`default_nettype wire

// [rtl/ctsr_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ctsr_cfg.svh"

module ctsr_top (
   input wire logic ref_clk,
   input wire logic srst,
   input wire ctsr_pkg::ctsr_io_req_t io_req,
   input wire logic enh_regs_locked,
   input wire ctsr_pkg::ctsr_pol_t misc_pol,
   output logic [7:0] io_rdata,
   output ctsr_pkg::ctsr_step_t cnt_step,
   output ctsr_pkg::ctsr_pol_t sync_pol
);

   ctsr_pkg::ctsr_state_t s_q;
   ctsr_pkg::ctsr_state_t s_d;

   logic [7:0] scr_rdata;
   logic scr_hit;
   logic scr_wr;
   logic ext_dat_wr;
   logic ext_dat_rd;
   logic dtcu_idx_port;
   logic dtcu_dat_port;

   localparam logic [7:0] SCR_BASE = `CTSR_IDX_SCRATCH_BASE;

   // Both mono and colour port pairs decode; the host picks one
   assign dtcu_idx_port = (io_req.addr == `CTSR_PORT_DTCU_IDX_MONO) ||
                          (io_req.addr == `CTSR_PORT_DTCU_IDX_COLR);
   assign dtcu_dat_port = (io_req.addr == `CTSR_PORT_DTCU_DAT_MONO) ||
                          (io_req.addr == `CTSR_PORT_DTCU_DAT_COLR);
   assign ext_dat_wr = io_req.wr && (io_req.addr == `CTSR_PORT_EXT_DAT);
   assign ext_dat_rd = io_req.rd && (io_req.addr == `CTSR_PORT_EXT_DAT);
   assign scr_hit = (s_q.ext_idx[7:3] == SCR_BASE[7:3]);
   assign scr_wr = ext_dat_wr && scr_hit;

   ctsr_scratch #(
      .DEPTH(`CTSR_SCRATCH_COUNT)
   ) u_scratch (
      .ref_clk(ref_clk),
      .srst(srst),
      .wr_en(scr_wr),
      .sel(s_q.ext_idx[2:0]),
      .wdata(io_req.wdata),
      .rdata(scr_rdata)
   );

   always_comb begin
      logic unlocked;
      logic any_rd;
      unlocked = !enh_regs_locked;
      any_rd = io_req.rd;
      s_d = s_q;
      s_d.rdata = `CTSR_BYTE_ZERO;

      if (io_req.wr) begin
         if (dtcu_idx_port) begin
            s_d.dtcu_idx = io_req.wdata;
         end else if (dtcu_dat_port && s_q.dtcu_idx == `CTSR_IDX_TEST) begin
            // Reserved bits never store
            s_d.test = io_req.wdata & `CTSR_TEST_WR_MASK;
         end else if (io_req.addr == `CTSR_PORT_EXT_IDX) begin
            s_d.ext_idx = io_req.wdata;
         end
      end

      // Read data answers one cycle after the strobe; unmapped reads give zero
      if (io_req.rd) begin
         if (dtcu_idx_port) begin
            s_d.rdata = s_q.dtcu_idx;
         end else if (dtcu_dat_port && s_q.dtcu_idx == `CTSR_IDX_TEST) begin
            s_d.rdata = s_q.test;
         end else if (io_req.addr == `CTSR_PORT_EXT_IDX) begin
            s_d.rdata = s_q.ext_idx;
         end else if (ext_dat_rd && s_q.ext_idx == `CTSR_IDX_LOCK) begin
            s_d.rdata = {7'h00, enh_regs_locked};
         end else if (ext_dat_rd && scr_hit) begin
            s_d.rdata = scr_rdata;
         end
      end

      // One step per host read, any port, only while unlocked
      s_d.step.vcnt_upper5 = any_rd && unlocked && s_q.test[`CTSR_TEST_VCNT5];
      s_d.step.vcnt_upper4 = any_rd && unlocked && s_q.test[`CTSR_TEST_VCNT4];
      s_d.step.hcnt_upper5 = any_rd && unlocked &&
                             (s_q.test[`CTSR_TEST_HCNT5A] ||
                              s_q.test[`CTSR_TEST_HCNT5B]);

      // Forcing overrides the misc output setting only while unlocked
      if (unlocked && s_q.test[`CTSR_TEST_FORCE_POL]) begin
         s_d.pol.hsync_high = 1'b1;
         s_d.pol.vsync_high = 1'b1;
      end else begin
         s_d.pol = misc_pol;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_q.dtcu_idx <= `CTSR_BYTE_ZERO;
         s_q.ext_idx <= `CTSR_BYTE_ZERO;
         s_q.test <= `CTSR_TEST_RESET;
         s_q.rdata <= `CTSR_BYTE_ZERO;
         s_q.step <= '0;
         s_q.pol <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign io_rdata = s_q.rdata;
   assign cnt_step = s_q.step;
   assign sync_pol = s_q.pol;

endmodule

`default_nettype wire

// [tb/ctsr_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module ctsr_chk (
   input wire logic ref_clk,
   input wire logic srst,
   input wire ctsr_pkg::ctsr_io_req_t io_req,
   input wire logic enh_regs_locked,
   input wire ctsr_pkg::ctsr_pol_t misc_pol,
   input wire logic [7:0] io_rdata,
   input wire ctsr_pkg::ctsr_step_t cnt_step,
   input wire ctsr_pkg::ctsr_pol_t sync_pol
);
   logic [7:0] ci_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   always_ff @(posedge ref_clk)
      if (srst)
         ci_q <= 8'h00;
      else if (io_req.wr && io_req.addr inside {16'h03b4, 16'h03d4})
         ci_q <= io_req.wdata;
   sequence s_trd;
      io_req.rd && ci_q == 8'h2f && io_req.addr inside {16'h03b5, 16'h03d5};
   endsequence
   AST_STP: assert property (cnt_step != 3'b000 |-> $past(io_req.rd))
      else $error("step");
   AST_LCK: assert property ($past(enh_regs_locked) |-> cnt_step == 3'b000)
      else $error("lock");
   AST_RD0: assert property (!$past(io_req.rd) |-> io_rdata == 8'h00)
      else $error("rd0");
   AST_PLK: assert property ($past(enh_regs_locked) |-> sync_pol == $past(misc_pol))
      else $error("plk");
   AST_PS: assert property (sync_pol == $past(misc_pol) || sync_pol == 2'b11)
      else $error("pol");
   AST_RSV: assert property (s_trd |=> io_rdata[3:1] == 3'b000)
      else $error("rsv");
   AST_TST: assert property (s_trd ##0 !enh_regs_locked |=>
      cnt_step == {io_rdata[7:6], |io_rdata[5:4]}) else $error("tst");
   AST_FRC: assert property (s_trd ##0 !enh_regs_locked |=>
      sync_pol == (io_rdata[0] ? 2'b11 : $past(misc_pol))) else $error("frc");
endmodule
bind ctsr_top ctsr_chk u_chk (.ref_clk, .srst, .io_req, .enh_regs_locked, .misc_pol,
   .io_rdata, .cnt_step, .sync_pol);
`default_nettype wire

// [tb/display_timing_counter_unit_test_and_scratch_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module display_timing_counter_unit_test_and_scratch_regs_tb;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic lk = 1'b1;
   logic nl = 1'b1;
   ctsr_pkg::ctsr_io_req_t io_req = '0;
   ctsr_pkg::ctsr_pol_t misc_pol = '0;
   logic [7:0] io_rdata;
   ctsr_pkg::ctsr_step_t cnt_step;
   ctsr_pkg::ctsr_pol_t sync_pol;
   logic [12:0] got;
   int failures = 0;
   int total_checks = 0;
   always #50 ref_clk = ~ref_clk;
   ctsr_top u_dut (.ref_clk, .srst, .io_req, .enh_regs_locked(lk), .misc_pol, .io_rdata,
      .cnt_step, .sync_pol);
   task final_report;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Lock moves with a request so it never changes on a sampling edge
   task io(input logic r, input logic [15:0] a, input logic [7:0] d);
      #10 io_req = '{r, !r, a, d};
      lk = nl;
      @(posedge ref_clk);
      #10 got = {io_rdata, cnt_step, sync_pol};
      io_req = '0;
      @(posedge ref_clk);
   endtask
   task wr2(input logic [15:0] a, input logic [7:0] i, input logic [7:0] d);
      io(1'b0, a, i);
      io(1'b0, a + 16'h0001, d);
   endtask
   task rx(input logic [15:0] a, input logic [7:0] i, input logic [12:0] e);
      io(1'b0, a, i);
      io(1'b1, a + 16'h0001, 8'h00);
      total_checks++;
      if (got !== e) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
      end
   endtask
   task t_scratch;
      for (int i = 0; i < 8; i++)
         wr2(16'h03c4, 8'h88 + 8'(i), 8'h15 ^ 8'(i));
      for (int i = 0; i < 8; i++)
         rx(16'h03c4, 8'h88 + 8'(i), {8'h15 ^ 8'(i), 5'h01});
      rx(16'h03c4, 8'h81, {8'h01, 5'h01});
   endtask
   task t_test;
      nl = 1'b0;
      rx(16'h03d4, 8'h2f, {8'h00, 5'h01});
      wr2(16'h03d4, 8'h2f, 8'hff);
      rx(16'h03d4, 8'h2f, {8'hf1, 5'h1f});
      wr2(16'h03b4, 8'h2f, 8'h6f);
      rx(16'h03b4, 8'h2f, {8'h61, 5'h0f});
      nl = 1'b1;
      wr2(16'h03d4, 8'h2f, 8'h91);
      rx(16'h03d4, 8'h2f, {8'h91, 5'h01});
      nl = 1'b0;
      rx(16'h0000, 8'h00, {8'h00, 5'h17});
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      misc_pol <= 2'b01;
      t_scratch;
      t_test;
      final_report;
   end
   initial begin
      #100000;
      failures++;
      final_report;
   end
endmodule
`default_nettype wire
